// [bench/bgpg_host.sv]
// Host controller model: serial master for the limit registers
`timescale 1ns/100ps
module bgpg_host (
  input  wire logic clk_in,      // Oscillator clock
  output logic      sclk_out,    // Serial clock, still between frames
  output logic      csb_n_out,   // Chip select, low
  output logic      mosi_out,    // Serial data to device
  input  wire logic miso_in      // Serial data from device
);
  initial begin
    sclk_out  = 1'b0;
    csb_n_out = 1'b1;
    mosi_out  = 1'b0;
  end

  // Four clocks per level keeps well above the one-clock sampling need
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One 16-bit frame; cap codes stay at or below 64h, well above coil peaks
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] f;
    f = {cmd, wd};
    rd = 8'h00;
    csb_n_out = 1'b0;
    for (int i = 0; i < 16; i++) begin
      mosi_out = f[15-i];
      step(4);
      if (i >= 8) begin
        rd = {rd[6:0], miso_in};    // Read bit has stood since the last fall
      end
      sclk_out = 1'b1;
      step(4);
      sclk_out = 1'b0;
    end
    step(4);
    csb_n_out = 1'b1;
    mosi_out  = ~mosi_out;          // Released line does not keep its last bit
    step(4);
  endtask
endmodule

// [bench/bgpg_top_sva.sv]
// Concurrent checks on the ports of the protection gating top
`timescale 1ns/100ps
module bgpg_top_chk (
  input wire logic        clk_in,            // Oscillator clock
  input wire logic        arst_n_in,         // Async reset, low
  input wire logic        spi_sclk_in,       // Serial clock
  input wire logic        spi_csb_n_in,      // Chip select, low
  input wire logic        spi_mosi_in,       // Serial data in
  input wire logic        spi_miso_out,      // Serial data out
  input wire logic [3:0]  pwm_in,            // Raw drive pulses
  input wire logic        cycle_start_in,    // Cycle start pulse
  input wire logic [3:0]  phase_sel_in,      // Phase to output map
  input wire logic [7:0]  tj_code_in,        // Junction temperature code
  input wire logic [1:0]  ov_cmp_in,         // Overvoltage comparators
  input wire logic [3:0]  oc_cmp_in,         // Current comparators
  input wire logic [3:0]  gate_out,          // Gate drive
  input wire logic [1:0][16:0] ov_thr_out,   // Overvoltage thresholds
  input wire logic [1:0][16:0] oc_thr_out,   // Current thresholds
  input wire logic [1:0]  ov_hold_out,       // Overvoltage hold
  input wire logic [1:0]  slope_comp_on_out  // Slope compensation on
);
  // ---------------------------------------------------------------
  // Gating relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  // A gate may only follow its own raw pulse
  chk_gate_needs_pwm: assert property ((gate_out & ~$past(pwm_in)) == 4'h0)
    else $error("gate high without drive pulse");
  // Held output one blocks every phase mapped to it
  chk_ov_halt_one: assert property (ov_hold_out[0] |=> (gate_out & ~$past(phase_sel_in)) == 4'h0)
    else $error("output one gate toggles while held");
  // Comparator of output two passes two sync flops, then blocks the gates
  chk_ov_sync_two: assert property (ov_cmp_in[1] |-> ##2 ov_hold_out[1] ##1
    (gate_out & $past(phase_sel_in)) == 4'h0) else $error("output two hold late");
  // Current trip ends the pulse three clocks after the comparator
  chk_oc_trip_off: assert property ((oc_cmp_in != 4'h0) |-> ##3
    ((gate_out & $past(oc_cmp_in, 3)) == 4'h0)) else $error("current trip missed");
  // Output code zero keeps the phases quiet; three clocks cover the register lag
  chk_off_out_one: assert property (!slope_comp_on_out[0] [*3] |->
    (gate_out & ~phase_sel_in) == 4'h0) else $error("output one off but gating");
  chk_off_out_two: assert property (!slope_comp_on_out[1] [*3] |->
    (gate_out & phase_sel_in) == 4'h0) else $error("output two off but gating");
  // Current cap zero shows as the bare offset and allows no gate
  chk_cap_zero_off: assert property ((oc_thr_out[0] == 17'h1ddde) [*3] |->
    (gate_out & ~phase_sel_in) == 4'h0) else $error("zero cap but gating");

  // ---------------------------------------------------------------
  // Threshold arithmetic and update moment
  // ---------------------------------------------------------------
  chk_oc_step_size: assert property ($past(arst_n_in) |->
    ((oc_thr_out[0] + 17'h02222) & 17'h000ff) == 17'h00000) else $error("current step wrong");
  // At reference temperature the threshold is a whole number of steps, top at FFh
  chk_ov_ref_scale: assert property ((tj_code_in == 8'h26) && $stable(tj_code_in) |->
    (ov_thr_out[1][7:0] == 8'h00) && (ov_thr_out[1] <= 17'h0ff00)) else $error("ov scale wrong");
  // Current limits only move two clocks after a cycle start
  chk_new_limit_cyc: assert property ($past(arst_n_in, 2) && $changed(oc_thr_out[1]) |->
    $past(cycle_start_in, 2)) else $error("limit changed mid cycle");

  cover property (ov_hold_out[0]);
  cover property (oc_cmp_in[2] ##3 !gate_out[2]);
  cover property ($fell(slope_comp_on_out[1]));
endmodule

bind bgpg_top bgpg_top_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .spi_sclk_in(spi_sclk_in), .spi_csb_n_in(spi_csb_n_in), .spi_mosi_in(spi_mosi_in),
  .spi_miso_out(spi_miso_out), .pwm_in(pwm_in), .cycle_start_in(cycle_start_in),
  .phase_sel_in(phase_sel_in), .tj_code_in(tj_code_in), .ov_cmp_in(ov_cmp_in),
  .oc_cmp_in(oc_cmp_in), .gate_out(gate_out), .ov_thr_out(ov_thr_out),
  .oc_thr_out(oc_thr_out), .ov_hold_out(ov_hold_out), .slope_comp_on_out(slope_comp_on_out));

// [bench/test_boost_gate_protection_gating.sv]
// Self-checking testbench for the protection gating top
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_boost_gate_protection_gating;
  logic            clk_in;       // 50 MHz clock
  logic            arst_n_in;    // Reset, low
  logic            sclk;         // Serial clock from host
  logic            csb_n;        // Chip select from host
  logic            mosi;         // Serial data from host
  logic            miso;         // Serial data to host
  logic [3:0]      pwm_in;       // Raw pulses
  logic            cyc;          // Cycle start
  logic [3:0]      sel;          // Phase map
  logic [7:0]      tj;           // Temperature code
  logic [1:0]      ov_cmp;       // Overvoltage comparators
  logic [3:0]      oc_cmp;       // Current comparators
  logic [3:0]      gate;         // Gate drive
  logic [1:0][16:0] ov_thr;      // Overvoltage thresholds
  logic [1:0][16:0] oc_thr;      // Current thresholds
  logic [1:0]      ov_hold;      // Hold flags
  logic [1:0]      slope;        // Slope compensation flags
  logic [7:0]      rd;           // Read data
  int              err_count;    // Mismatches
  int              n_compared;   // Comparisons made
  logic [7:0]      exp_reg [4];  // Expected register contents

  bgpg_top DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .spi_sclk_in(sclk),
    .spi_csb_n_in(csb_n), .spi_mosi_in(mosi), .spi_miso_out(miso), .pwm_in(pwm_in),
    .cycle_start_in(cyc), .phase_sel_in(sel), .tj_code_in(tj), .ov_cmp_in(ov_cmp),
    .oc_cmp_in(oc_cmp), .gate_out(gate), .ov_thr_out(ov_thr), .oc_thr_out(oc_thr),
    .ov_hold_out(ov_hold), .slope_comp_on_out(slope));
  bgpg_host host (.clk_in(clk_in), .sclk_out(sclk), .csb_n_out(csb_n), .mosi_out(mosi),
    .miso_in(miso));

  // ---------------------------------------------------------------
  // Clock, helpers and closing
  // ---------------------------------------------------------------
  always #10 clk_in = ~clk_in;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a}, d, rd);
  endtask
  // Cycle start is a single-clock pulse; limits then settle two clocks later
  task automatic cycle();
    cyc = 1'b1;
    tick(1);
    cyc = 1'b0;
    tick(3);
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: the whole run is far shorter than this
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0; arst_n_in = 1'b0; pwm_in = 4'h0; cyc = 1'b0; sel = 4'hc;
    tj = 8'h26; ov_cmp = 2'h0; oc_cmp = 4'h0; err_count = 0; n_compared = 0;
    exp_reg = '{8'h80, 8'hff, 8'h64, 8'h01};
    tick(6);
    `CHK("gate_in_reset", 4'h0, gate)
    arst_n_in = 1'b1;
    tick(2);
    `CHK("oc_thr_reset", 17'h1ddde, oc_thr[0])
    for (int a = 5; a < 9; a++) begin
      host.xfer(8'(a), 8'h00, rd);
      `CHK("reg_reset", 8'h00, rd)
    end
    $display("test reset done");

    // Limits about five volts above target; caps within the legal range
    for (int a = 0; a < 4; a++) wr(7'(a + 5), exp_reg[a]);
    `CHK("ov_thr_before_cycle", 17'h00000, ov_thr[0])
    cycle();
    `CHK("ov_thr_one", 17'h08000, ov_thr[0])
    `CHK("ov_thr_full", 17'h0ff00, ov_thr[1])
    `CHK("oc_thr_max", 17'h041de, oc_thr[0])
    `CHK("oc_thr_min", 17'h1dede, oc_thr[1])
    for (int a = 0; a < 4; a++) begin
      host.xfer(8'(a + 5), 8'h00, rd);
      `CHK("reg_readback", exp_reg[a], rd)
    end
    host.xfer(8'h10, 8'h00, rd);
    `CHK("unmapped_read", 8'h00, rd)
    tj = 8'h27;
    tick(3);
    `CHK("ov_thr_hot", 1'b1, ov_thr[0] > 17'h08000)
    tj = 8'h26;
    tick(3);
    $display("test config done");

    pwm_in = 4'hf;
    tick(3);
    `CHK("gate_run", 4'hf, gate)
    ov_cmp = 2'h1;
    tick(4);
    `CHK("gate_ov_one", 4'hc, gate)
    `CHK("hold_ov_one", 2'h1, ov_hold)
    ov_cmp = 2'h0;
    tick(4);
    `CHK("gate_resume", 4'hf, gate)
    ov_cmp = 2'h2;
    tick(4);
    `CHK("gate_ov_two", 4'h3, gate)
    `CHK("hold_ov_two", 2'h2, ov_hold)
    ov_cmp = 2'h0;
    tick(4);
    `CHK("gate_resume_two", 4'hf, gate)
    oc_cmp = 4'h4;
    tick(1);
    `CHK("gate_before_sync", 4'hf, gate)
    tick(3);
    `CHK("gate_trip", 4'hb, gate)
    `CHK("slope_in_trip", 2'h3, slope)
    oc_cmp = 4'h0;
    tick(4);
    `CHK("gate_trip_held", 4'hb, gate)
    cycle();
    `CHK("gate_rearm", 4'hf, gate)
    $display("test gating done");

    wr(7'h07, 8'h00);
    `CHK("cap_zero_pending", 4'hf, gate)
    cycle();
    `CHK("gate_cap_zero", 4'hc, gate)
    wr(7'h07, 8'h64);
    wr(7'h06, 8'h00);
    cycle();
    `CHK("gate_out_two_off", 4'h3, gate)
    `CHK("slope_out_two_off", 2'h1, slope)
    wr(7'h05, 8'h00);
    cycle();
    `CHK("gate_all_off", 4'h0, gate)
    `CHK("slope_all_off", 2'h0, slope)
    $display("test off codes done");
    final_report();
  end
endmodule

// [rtl/bgpg_ov_thresh.sv]
// Overvoltage threshold and comparator synchroniser for one output
`timescale 1ns/100ps
module bgpg_ov_thresh (
  input  wire logic                           clk_in,     // Oscillator clock
  input  wire logic                           arst_n_in,  // Async reset, low
  input  wire logic [bgpg_pkg::CODE_W-1:0]    code_in,    // Active limit code
  input  wire logic [7:0]                     tj_in,      // Junction temperature code
  input  wire logic                           cmp_in,     // Output above threshold
  output logic      [bgpg_pkg::OV_THR_W-1:0]  thr_out,    // Threshold, 1/256 code steps
  output logic                                over_out    // Synchronised overvoltage
);

  // ---------------------------------------------------------------
  // Threshold arithmetic
  // ---------------------------------------------------------------
  logic signed [9:0]  tdiff;    // Temperature step from reference
  logic signed [17:0] factor;   // Correction factor, 2^-16 units
  logic signed [26:0] prod;     // Code times factor
  logic [bgpg_pkg::OV_THR_W-1:0] thr_nxt;
  logic [bgpg_pkg::OV_THR_W-1:0] thr_r;
  logic meta_r;                 // First synchroniser stage
  logic sync_r;                 // Second synchroniser stage

  // Factor stays positive over the whole code range, so no clamp is needed
  always_comb begin
    tdiff   = $signed({2'h0, tj_in}) - $signed({2'h0, bgpg_pkg::TJ_REF});
    factor  = bgpg_pkg::TC_UNITY + 18'(bgpg_pkg::TC_GAIN * 18'(tdiff));
    prod    = $signed({19'h0, code_in}) * 27'(factor);
    thr_nxt = prod[bgpg_pkg::OV_FRAC_LSB +: bgpg_pkg::OV_THR_W];
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Comparator is asynchronous to the drive; two flops keep glitches off the gates
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      thr_r  <= '0;
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      thr_r  <= thr_nxt;
      meta_r <= cmp_in;
      sync_r <= meta_r;
    end
  end

  assign thr_out  = thr_r;
  assign over_out = sync_r;

endmodule

// [rtl/bgpg_phase_gate.sv]
// Gate slice for one phase: current trip latch and final gating
`timescale 1ns/100ps
module bgpg_phase_gate (
  input  wire logic clk_in,     // Oscillator clock
  input  wire logic arst_n_in,  // Async reset, low
  bgpg_phase_if.phase ph        // Signals from and to the core
);

  typedef enum logic {BGPG_ARMED, BGPG_TRIPPED} bgpg_trip_e;

  bgpg_trip_e st_r;       // Trip state within the cycle
  bgpg_trip_e st_nxt;
  logic       meta_r;     // First synchroniser stage
  logic       sync_r;     // Second synchroniser stage
  logic       gate_r;     // Registered gate drive
  logic       gate_nxt;

  // Trip latch; a new cycle re-arms, a synchronised trip ends the pulse
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      BGPG_ARMED: begin
        if (sync_r && !ph.cycle_start) begin
          st_nxt = BGPG_TRIPPED;
        end
      end
      BGPG_TRIPPED: begin
        if (ph.cycle_start) begin
          st_nxt = BGPG_ARMED;
        end
      end
      default: begin
        st_nxt = BGPG_ARMED;
      end
    endcase
    // Trip also blocks the very cycle it is seen, saving one clock of on time
    gate_nxt = ph.pwm && !ph.hold && !sync_r && (st_nxt == BGPG_ARMED);
  end

  // Registers, including the comparator synchroniser
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r   <= BGPG_ARMED;
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      gate_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      meta_r <= ph.cmp_raw;
      sync_r <= meta_r;
      gate_r <= gate_nxt;
    end
  end

  assign ph.gate = gate_r;

endmodule

// [rtl/bgpg_phase_if.sv]
// Interface between the core and one phase gating slice
`timescale 1ns/100ps
interface bgpg_phase_if;
  logic pwm;          // Raw drive pulse from regulation loop
  logic cycle_start;  // First clock of a switching cycle
  logic hold;         // Output off, overvoltage or zero current cap
  logic cmp_raw;      // Current sense comparator, unsynchronised
  logic gate;         // Final gate drive, registered

  modport core  (output pwm, output cycle_start, output hold, output cmp_raw, input gate);
  modport phase (input pwm, input cycle_start, input hold, input cmp_raw, output gate);
endinterface

// [rtl/bgpg_pkg.sv]
// Constants shared by the boost gate protection gating block
//
// Summary of operation
// - Limit code zero turns output one off
// - Limit code zero turns output two off
// - Overvoltage threshold is code times temperature-corrected step
// - All-ones limit code is top threshold
// - Output above threshold halts all its gates
// - Gates resume once output falls below threshold
// - Output current limit applies to its phases
// - Sense trip holds gate off until next cycle
// - Slope compensation stays on while current limiting
// - Current threshold is code step minus offset
package bgpg_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_OUT  = 2;           // Independent outputs
  localparam int unsigned NUM_PH   = 4;           // Gate drive phases
  localparam int unsigned NUM_LIM  = 4;           // Limit registers
  localparam int unsigned CODE_W   = 8;           // Limit code width
  localparam int unsigned OV_THR_W = 17;          // Overvoltage threshold width
  localparam int unsigned OC_THR_W = 17;          // Current threshold width

  // ---------------------------------------------------------------
  // Register map, seven bit address
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_OV1 = 7'h05;        // overvoltage_limit_out1
  localparam logic [6:0] ADDR_OV2 = 7'h06;        // overvoltage_limit_out2
  localparam logic [6:0] ADDR_OC1 = 7'h07;        // peak_current_limit_out1
  localparam logic [6:0] ADDR_OC2 = 7'h08;        // peak_current_limit_out2
  localparam logic [1:0] IDX_OV1  = 2'h0;         // Storage index of first limit
  localparam logic [1:0] IDX_OC1  = 2'h2;         // Storage index of first current cap
  localparam logic [7:0] LIMIT_RST = 8'h00;       // Reset value: everything off
  localparam logic [7:0] READ_NONE = 8'h00;       // Answer for unmapped reads

  // ---------------------------------------------------------------
  // Code meanings
  // ---------------------------------------------------------------
  localparam logic [7:0] CODE_OFF  = 8'h00;       // Output off / no current
  localparam logic [7:0] CODE_FULL = 8'hff;       // Top threshold, 90 V
  localparam logic [7:0] OC_MAX    = 8'h64;       // Highest legal current code

  // ---------------------------------------------------------------
  // Threshold arithmetic
  // ---------------------------------------------------------------
  localparam logic [7:0] TJ_REF = 8'h26;               // Reference junction code 38
  localparam logic signed [17:0] TC_UNITY = 18'sh10000; // 1.0 in 2^-16 units
  localparam logic signed [17:0] TC_GAIN  = 18'sh00016; // 333 ppm in 2^-16 units
  localparam int unsigned OV_FRAC_LSB = 8;             // Product bit of 2^-8 code
  localparam logic signed [16:0] OC_OFFSET = 17'sh02222; // 0.24 V in 1.8V/65536

  // ---------------------------------------------------------------
  // Serial frame
  // ---------------------------------------------------------------
  localparam logic [4:0] SPI_CMD_LAST = 5'h07;    // Count at last command bit
  localparam logic [4:0] SPI_LAST     = 5'h0f;    // Count at last data bit
  localparam logic [4:0] SPI_DONE     = 5'h10;    // Frame complete, extra bits ignored
  localparam int unsigned SPI_WR_BIT  = 7;        // Write flag in command byte

endpackage

// [rtl/bgpg_top.sv]
// Protection gating top: serial register port, limit shadows, phase gating
`timescale 1ns/100ps
module bgpg_top (
  input  wire logic        clk_in,             // Oscillator clock, 50 MHz
  input  wire logic        arst_n_in,          // Async reset, low
  input  wire logic        spi_sclk_in,        // Serial clock
  input  wire logic        spi_csb_n_in,       // Chip select, low
  input  wire logic        spi_mosi_in,        // Serial data in
  output logic             spi_miso_out,       // Serial data out
  input  wire logic [3:0]  pwm_in,             // Drive pulses from regulation loop
  input  wire logic        cycle_start_in,     // Switching cycle start pulse
  input  wire logic [3:0]  phase_sel_in,       // Phase to output map, 1 = second
  input  wire logic [7:0]  tj_code_in,         // Junction temperature code
  input  wire logic [1:0]  ov_cmp_in,          // Output above threshold
  input  wire logic [3:0]  oc_cmp_in,          // Sense drop reached peak limit
  output logic      [3:0]  gate_out,           // Gate drive per phase
  output logic [1:0][16:0] ov_thr_out,         // Overvoltage thresholds
  output logic [1:0][16:0] oc_thr_out,         // Peak current thresholds, signed
  output logic      [1:0]  ov_hold_out,        // Output held by overvoltage
  output logic      [1:0]  slope_comp_on_out   // Slope compensation active
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  localparam int unsigned NP = bgpg_pkg::NUM_PH;   // Phase count
  localparam int unsigned NO = bgpg_pkg::NUM_OUT;  // Output count
  localparam int unsigned NL = bgpg_pkg::NUM_LIM;  // Limit register count

  // Serial shifter state
  logic        sclk_prev_r;   // Serial clock one sample ago
  logic        sclk_prev_nxt;
  logic [4:0]  bit_cnt_r;     // Bits received in this frame
  logic [4:0]  bit_cnt_nxt;
  logic [15:0] shift_in_r;    // Received bits, newest in bit 0
  logic [15:0] shift_in_nxt;
  logic [7:0]  shift_out_r;   // Read data waiting to leave
  logic [7:0]  shift_out_nxt;
  logic        miso_r;        // Registered serial output
  logic        miso_nxt;

  // Limit storage: host-written copy and cycle-aligned active copy
  logic [NL-1:0][7:0] lim_r;
  logic [NL-1:0][7:0] lim_nxt;
  logic [NL-1:0][7:0] act_r;
  logic [NL-1:0][7:0] act_nxt;

  // Per output derived state
  logic [NO-1:0]       out_off;       // Limit code zero
  logic [NO-1:0]       cap_zero;      // Current cap code zero
  logic [NO-1:0]       ov_over;       // Synchronised overvoltage
  logic [NO-1:0][16:0] oc_thr_r;      // Current thresholds
  logic [NO-1:0][16:0] oc_thr_nxt;
  logic [NO-1:0]       slope_on_r;    // Slope compensation enable
  logic [NO-1:0]       slope_on_nxt;

  // Serial decode helpers
  logic       sclk_rise;   // Serial clock rose this sample
  logic       sclk_fall;   // Serial clock fell this sample
  logic [7:0] cmd_byte;    // Command byte as it completes
  logic [7:0] wr_cmd;      // Command byte at the last data bit
  logic [7:0] wr_data;     // Data byte at the last data bit
  logic [2:0] rd_dec;      // Hit and index of the read command
  logic [2:0] wr_dec;      // Hit and index of the write command

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Four limits sit on consecutive addresses; anything else misses
  function automatic logic [2:0] lim_decode(input logic [6:0] addr);
    logic hit;
    hit = (addr >= bgpg_pkg::ADDR_OV1) && (addr <= bgpg_pkg::ADDR_OC2);
    return {hit, 2'(addr - bgpg_pkg::ADDR_OV1)};
  endfunction

  // ---------------------------------------------------------------
  // Serial register port
  // ---------------------------------------------------------------
  // Inputs are sampled on the oscillator, so the host serial clock must be
  // well below half the oscillator rate
  always_comb begin
    sclk_prev_nxt = spi_sclk_in;
    bit_cnt_nxt   = bit_cnt_r;
    shift_in_nxt  = shift_in_r;
    shift_out_nxt = shift_out_r;
    miso_nxt      = miso_r;
    lim_nxt       = lim_r;
    sclk_rise     = spi_sclk_in && !sclk_prev_r;
    sclk_fall     = !spi_sclk_in && sclk_prev_r;
    cmd_byte      = {shift_in_r[6:0], spi_mosi_in};
    wr_cmd        = shift_in_r[14:7];
    wr_data       = {shift_in_r[6:0], spi_mosi_in};
    rd_dec        = lim_decode(cmd_byte[6:0]);
    wr_dec        = lim_decode(wr_cmd[6:0]);
    if (spi_csb_n_in) begin
      // Deselected: frame restarts, output parks low
      bit_cnt_nxt = '0;
      miso_nxt    = 1'b0;
    end else if (sclk_rise && (bit_cnt_r != bgpg_pkg::SPI_DONE)) begin
      shift_in_nxt = {shift_in_r[14:0], spi_mosi_in};
      bit_cnt_nxt  = bit_cnt_r + 5'h01;
      if (bit_cnt_r == bgpg_pkg::SPI_CMD_LAST) begin
        // Command complete: fetch read data; unmapped reads give zero
        if (rd_dec[2]) begin
          shift_out_nxt = lim_r[rd_dec[1:0]];
        end else begin
          shift_out_nxt = bgpg_pkg::READ_NONE;
        end
      end
      if ((bit_cnt_r == bgpg_pkg::SPI_LAST) && wr_cmd[bgpg_pkg::SPI_WR_BIT]) begin
        // Writes to unmapped addresses are dropped; codes are stored as sent
        if (wr_dec[2]) begin
          lim_nxt[wr_dec[1:0]] = wr_data;
        end
      end
    end else if (sclk_fall && (bit_cnt_r > bgpg_pkg::SPI_CMD_LAST)
                 && (bit_cnt_r < bgpg_pkg::SPI_DONE)) begin
      // Data phase: next read bit leaves on the falling edge
      miso_nxt      = shift_out_r[7];
      shift_out_nxt = {shift_out_r[6:0], 1'b0};
    end
  end

  // Serial port registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_prev_r <= 1'b0;
      bit_cnt_r   <= '0;
      shift_in_r  <= '0;
      shift_out_r <= '0;
      miso_r      <= 1'b0;
      lim_r       <= {NL{bgpg_pkg::LIMIT_RST}};
    end else begin
      sclk_prev_r <= sclk_prev_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      shift_in_r  <= shift_in_nxt;
      shift_out_r <= shift_out_nxt;
      miso_r      <= miso_nxt;
      lim_r       <= lim_nxt;
    end
  end

  assign spi_miso_out = miso_r;

  // ---------------------------------------------------------------
  // Active limit copy
  // ---------------------------------------------------------------
  // Limits change only at a cycle boundary, so a pulse never sees two
  // different limit codes; a write landing on the boundary is taken too
  always_comb begin
    act_nxt = act_r;
    if (cycle_start_in) begin
      act_nxt = lim_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      act_r <= {NL{bgpg_pkg::LIMIT_RST}};
    end else begin
      act_r <= act_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Per output protection
  // ---------------------------------------------------------------
  genvar go;
  generate
    for (go = 0; go < NO; go++) begin : g_out
      // Overvoltage threshold and synchronised comparator
      bgpg_ov_thresh u_ov (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .code_in   (act_r[bgpg_pkg::IDX_OV1 + 2'(go)]),
        .tj_in     (tj_code_in),
        .cmp_in    (ov_cmp_in[go]),
        .thr_out   (ov_thr_out[go]),
        .over_out  (ov_over[go])
      );
    end
  endgenerate

  // Output off and zero-cap decode, current thresholds, slope enable
  always_comb begin
    for (int o = 0; o < NO; o++) begin
      out_off[o]  = act_r[bgpg_pkg::IDX_OV1 + 2'(o)] == bgpg_pkg::CODE_OFF;
      cap_zero[o] = act_r[bgpg_pkg::IDX_OC1 + 2'(o)] == bgpg_pkg::CODE_OFF;
      // Code times 1.8 V/256 less 0.24 V, kept in 1.8 V/65536 units
      oc_thr_nxt[o] = 17'($signed({1'b0, act_r[bgpg_pkg::IDX_OC1 + 2'(o)], 8'h00})
                          - bgpg_pkg::OC_OFFSET);
      // Slope compensation ignores current trips so the limit stays stable
      slope_on_nxt[o] = !out_off[o];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      oc_thr_r   <= '0;
      slope_on_r <= '0;
    end else begin
      oc_thr_r   <= oc_thr_nxt;
      slope_on_r <= slope_on_nxt;
    end
  end

  assign oc_thr_out        = oc_thr_r;
  assign slope_comp_on_out = slope_on_r;
  assign ov_hold_out       = ov_over;

  // ---------------------------------------------------------------
  // Phase slices
  // ---------------------------------------------------------------
  bgpg_phase_if ph_if [NP] ();

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_ph
      // Each phase follows the limits of the output it is mapped to
      assign ph_if[gp].pwm         = pwm_in[gp];
      assign ph_if[gp].cycle_start = cycle_start_in;
      assign ph_if[gp].cmp_raw     = oc_cmp_in[gp];
      assign ph_if[gp].hold        = out_off[phase_sel_in[gp]]
                                   || ov_over[phase_sel_in[gp]]
                                   || cap_zero[phase_sel_in[gp]];
      assign gate_out[gp]          = ph_if[gp].gate;

      bgpg_phase_gate u_gate (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .ph        (ph_if[gp])
      );
    end
  endgenerate

endmodule
